// ===== instruction_timing_decode_tb.sv
// self-checking bench for the instruction decoder
module instruction_timing_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import itd_pkg::*;
    localparam int N = 120;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [INSN_W-1:0] insn;
    logic skip_cond, ptr_sel_q, dest_file_q, file_rd_q, file_wr_q, acc_wr_q, exec_q, squash_q, insn_done_q;
    logic [1:0] ptr_in_prog, group_q, ptr_mode_q, phase_q;
    logic [3:0] op_q;
    logic [FADDR_W-1:0] faddr_q;
    logic [BIT_W-1:0] bitnum_q;
    logic [LIT11_W-1:0] literal_q;
    logic [13:0] pw [256];
    logic ps [256];
    logic [1:0] pq [256];
    int n_mismatch, comparisons, k, rem, gap;
    logic first;
    localparam logic [13:0] CORNER [21] = '{OPC_RETURN, OPC_RETFROMINT, OPC_CALLACC, OPC_BRACC,
        14'h0010, 14'h0011, 14'h0012, 14'h0013, 14'h0014, 14'h0015, 14'h0016, 14'h0017,
        14'h2123, 14'h2fff, 14'h34a5, 14'h3355, 14'h0f01, 14'h0b80, 14'h1801, 14'h1f80, 14'h047f};

    always #12.5ns clk = ~clk;

    itd_decoder dut (.clk, .rst, .insn, .skip_cond, .ptr_in_prog, .group_q, .op_q, .faddr_q,
        .dest_file_q, .bitnum_q, .literal_q, .ptr_sel_q, .ptr_mode_q, .file_rd_q, .file_wr_q,
        .acc_wr_q, .phase_q, .exec_q, .squash_q, .insn_done_q);
    itd_fetch_model mdl (.clk, .rst, .insn_done_q, .insn, .skip_cond, .ptr_in_prog);

    task automatic chk_fld(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t field got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t timing got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic itd_op_e exp_op(input logic [13:0] w);
        if (w == OPC_RETURN) return ITD_OP_RETURN;
        if (w == OPC_RETFROMINT) return ITD_OP_RETURN_FROM_INTERRUPT;
        if (w == OPC_CALLACC) return ITD_OP_CALL_VIA_ACC;
        if (w == OPC_BRACC) return ITD_OP_BRANCH_BY_ACC;
        if (w[13:3] == OPC_PTROP_TOP) return ITD_OP_POINTER_OP;
        if (w[13:8] == OPC_DECSKIP_HI) return ITD_OP_DECREMENT_SKIP_ZERO;
        if (w[13:8] == OPC_INCSKIP_HI) return ITD_OP_INCREMENT_SKIP_ZERO;
        if (w[13:12] == GRP_BIT && w[11:10] == OPC_BITSET_HI) return ITD_OP_SKIP_IF_BIT_SET;
        if (w[13:12] == GRP_BIT && w[11:10] == OPC_BITCLR_HI) return ITD_OP_SKIP_IF_BIT_CLEAR;
        if (w[13:11] == OPC_CALL_TOP) return ITD_OP_CALL;
        if (w[13:11] == OPC_GOTO_TOP) return ITD_OP_JUMP;
        if (w[13:8] == OPC_RETLIT_HI) return ITD_OP_RETURN_WITH_LITERAL;
        if (w[13:9] == OPC_RELBR_TOP) return ITD_OP_RELATIVE_BRANCH;
        return ITD_OP_OTHER;
    endfunction

    // control words sitting in the byte region carry no file operand
    function automatic logic ctl(input logic [13:0] w);
        return w[13:7] == 7'h00;
    endfunction

    function automatic int exp_cyc(input logic [13:0] w, input logic s, input logic [1:0] p);
        itd_op_e op;
        int n;
        op = exp_op(w);
        n = (op >= ITD_OP_CALL && op <= ITD_OP_BRANCH_BY_ACC) ? 2 : 1;
        if (op >= ITD_OP_SKIP_IF_BIT_SET && op <= ITD_OP_INCREMENT_SKIP_ZERO && s) n = 2;
        if (!w[13] && !ctl(w) && ((w[6:0] == INDIRECT0_ADDR && p[0]) || (w[6:0] == INDIRECT1_ADDR && p[1]))) n++;
        return n;
    endfunction

    function automatic logic [13:0] rnd_word();
        case ($urandom % 3)
            0: return {6'(1 + $urandom % 15), 8'($urandom)};
            1: return {2'b01, 12'($urandom)};
            default: return {1'b1, 13'($urandom)};
        endcase
    endfunction

    // odd corners get taken skips and both pointers at program memory
    task automatic build();
        for (int i = 0; i < 256; i++) begin
            pw[i] = (i < 21) ? CORNER[i] : rnd_word();
            ps[i] = (i < 21) ? i[0] : 1'($urandom);
            pq[i] = (i < 21) ? {2{i[0]}} : 2'($urandom);
            mdl.put(i, pw[i], ps[i], pq[i]);
        end
    endtask

    task automatic check_fields(input logic [13:0] w);
        chk_fld(16'(faddr_q), 16'(w[6:0]));
        chk_fld(16'(dest_file_q), 16'(w[DEST_BIT]));
        chk_fld(16'(bitnum_q), 16'(w[9:7]));
        chk_fld(16'(literal_q), 16'(w[10:0]));
        chk_fld(16'(ptr_sel_q), 16'(w[PTR_BIT]));
        chk_fld(16'(ptr_mode_q), 16'(w[1:0]));
        chk_fld(16'(op_q), 16'(exp_op(w)));
        chk_fld(16'(group_q), (w[13] || ctl(w)) ? 16'h2 : 16'(w[13:12]));
        if (w[13] || ctl(w)) begin
            chk_fld(16'({file_rd_q, file_wr_q, acc_wr_q}), 16'h0);
        end else begin
            chk_fld(16'({file_rd_q, file_wr_q, acc_wr_q}), 16'({1'b1, w[12] | w[7], ~w[12] & ~w[7]}));
        end
    endtask

    always @(negedge clk) begin
        if (rst) begin
            k = 0;
            rem = 0;
            gap = 0;
            first = 1'b1;
            chk_cyc(16'({exec_q, squash_q, insn_done_q, file_rd_q, file_wr_q, acc_wr_q, op_q}), 16'h0);
        end else begin
            gap++;
            if (exec_q === 1'b1 || squash_q === 1'b1) begin
                chk_cyc(16'(gap == 4 || (first && gap >= 3 && gap <= 5)), 16'h1);
                chk_cyc(16'(phase_q), 16'(PHASE_LAST));
                chk_cyc(16'(exec_q & squash_q), 16'h0);
                first = 1'b0;
                gap = 0;
            end
            if (exec_q === 1'b1) begin
                chk_cyc(16'(rem), 16'h0);
                rem = exp_cyc(pw[k], ps[k], pq[k]) - 1;
                chk_cyc(16'(insn_done_q), 16'(rem == 0));
                check_fields(pw[k]);
                k++;
            end else if (squash_q === 1'b1) begin
                chk_cyc(16'(rem > 0), 16'h1);
                rem--;
                chk_cyc(16'(insn_done_q), 16'(rem == 0));
                chk_cyc(16'({file_rd_q, file_wr_q, acc_wr_q}), 16'h0);
            end
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wait_k(input int n);
        for (int t = 0; t < 20 * n && k < n; t++) @(negedge clk);
        if (k < n) begin
            n_mismatch++;
            conclude();
        end
    endtask

    initial begin
        void'($urandom(32'hf3941116));
        build();
        repeat (6) @(posedge clk);
        @(negedge clk) rst <= 1'b0;
        wait_k(N / 2);
        // reset in mid-program, then a fresh random program
        @(negedge clk) rst <= 1'b1;
        // swap the program only once reset holds, so no check reads a half-swapped table
        @(negedge clk);
        build();
        repeat (5) @(negedge clk);
        rst <= 1'b0;
        wait_k(N);
        conclude();
    end

    // run needs some 25 us; generous margin before declaring a hang
    initial begin
        #200us;
        n_mismatch++;
        conclude();
    end
endmodule

// ===== itd_decoder.sv
// instruction decoder and cycle timing for the 8-bit core
module itd_decoder
    import itd_pkg::*;
#(
    parameter int unsigned WORD_W = INSN_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fetched instruction
    input wire logic [WORD_W-1:0] insn,
    // execution feedback
    input wire logic skip_cond,
    input wire logic [1:0] ptr_in_prog,
    // decoded fields
    output logic [1:0] group_q,
    output logic [3:0] op_q,
    output logic [FADDR_W-1:0] faddr_q,
    output logic dest_file_q,
    output logic [BIT_W-1:0] bitnum_q,
    output logic [LIT11_W-1:0] literal_q,
    output logic ptr_sel_q,
    output logic [1:0] ptr_mode_q,
    // file register access strobes
    output logic file_rd_q,
    output logic file_wr_q,
    output logic acc_wr_q,
    // timing
    output logic [1:0] phase_q,
    output logic exec_q,
    output logic squash_q,
    output logic insn_done_q
);
    typedef enum logic [1:0] {
        ST_EXEC = 2'h0,
        ST_EXTRA1 = 2'h1,
        ST_EXTRA2 = 2'h3
    } itd_state_e;

    // opcode lookup for the op kind only; the group comes from group_of
    function automatic itd_op_e op_of(input logic [13:0] w);
        if (w[13:8] == OPC_DECSKIP_HI) begin
            return ITD_OP_DECREMENT_SKIP_ZERO;
        end else if (w[13:8] == OPC_INCSKIP_HI) begin
            return ITD_OP_INCREMENT_SKIP_ZERO;
        end else if (w[13:12] == GRP_BIT && w[11:10] == OPC_BITSET_HI) begin
            return ITD_OP_SKIP_IF_BIT_SET;
        end else if (w[13:12] == GRP_BIT && w[11:10] == OPC_BITCLR_HI) begin
            return ITD_OP_SKIP_IF_BIT_CLEAR;
        end else if (w[13:11] == OPC_CALL_TOP) begin
            return ITD_OP_CALL;
        end else if (w[13:11] == OPC_GOTO_TOP) begin
            return ITD_OP_JUMP;
        end else if (w[13:8] == OPC_RETLIT_HI) begin
            return ITD_OP_RETURN_WITH_LITERAL;
        end else if (w[13:9] == OPC_RELBR_TOP) begin
            return ITD_OP_RELATIVE_BRANCH;
        end else if (w == OPC_RETURN) begin
            return ITD_OP_RETURN;
        end else if (w == OPC_RETFROMINT) begin
            return ITD_OP_RETURN_FROM_INTERRUPT;
        end else if (w == OPC_CALLACC) begin
            return ITD_OP_CALL_VIA_ACC;
        end else if (w == OPC_BRACC) begin
            return ITD_OP_BRANCH_BY_ACC;
        end else if (w[13:3] == OPC_PTROP_TOP) begin
            return ITD_OP_POINTER_OP;
        end else begin
            return ITD_OP_OTHER;
        end
    endfunction

    function automatic itd_group_e group_of(input logic [13:0] w);
        case (w[13:12])
            // control words: the low bits never move them into the byte group
            GRP_BYTE: group_of = (w[13:7] == 7'h00) ? ITD_GROUP_LITCTL : ITD_GROUP_BYTE;
            GRP_BIT: group_of = ITD_GROUP_BIT;
            default: group_of = ITD_GROUP_LITCTL;
        endcase
    endfunction

    function automatic logic names_file(input itd_group_e g, input logic [13:0] w);
        // bit ops, and byte ops with a file operand except the zero-operand control words
        names_file = (g == ITD_GROUP_BIT) || (g == ITD_GROUP_BYTE && w[13:3] != OPC_PTROP_TOP
                     && !(w[13:8] == 6'h00 && w[7] == 1'b0));
    endfunction

    logic [1:0] phase;
    logic cycle_end;
    itd_state_e state_q;
    logic [1:0] extra_q;
    logic [13:0] word_d;
    itd_op_e op_d;
    itd_group_e grp_d;
    logic file_d;
    logic indirect_d;
    logic [1:0] extra_d;
    logic taken_d;

    itd_phase_gen #(
        .PHASE_COUNT(PHASES)
    ) u_phase (
        .clk(clk),
        .rst(rst),
        .phase_q(phase),
        .cycle_end_q(cycle_end)
    );

    always_comb begin
        word_d = insn[13:0];
        op_d = op_of(word_d);
        grp_d = group_of(word_d);
        file_d = names_file(grp_d, word_d);
        indirect_d = file_d && (word_d[6:0] == INDIRECT0_ADDR ? ptr_in_prog[0] :
                     word_d[6:0] == INDIRECT1_ADDR ? ptr_in_prog[1] : 1'b0);
        case (op_d)
            ITD_OP_CALL, ITD_OP_CALL_VIA_ACC, ITD_OP_JUMP: taken_d = 1'b1;
            ITD_OP_RETURN, ITD_OP_RETURN_WITH_LITERAL, ITD_OP_RETURN_FROM_INTERRUPT: taken_d = 1'b1;
            ITD_OP_RELATIVE_BRANCH, ITD_OP_BRANCH_BY_ACC: taken_d = 1'b1;
            ITD_OP_SKIP_IF_BIT_SET, ITD_OP_SKIP_IF_BIT_CLEAR,
            ITD_OP_DECREMENT_SKIP_ZERO, ITD_OP_INCREMENT_SKIP_ZERO: taken_d = skip_cond;
            default: taken_d = 1'b0;
        endcase
        extra_d = {1'b0, taken_d} + {1'b0, indirect_d};
    end

    // one decode per instruction cycle, at its last phase
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_EXEC;
            extra_q <= 2'h0;
        end else if (cycle_end) begin
            case (state_q)
                ST_EXEC: begin
                    extra_q <= extra_d;
                    state_q <= (extra_d != 2'h0) ? ST_EXTRA1 : ST_EXEC;
                end
                ST_EXTRA1: state_q <= (extra_q == CYC_TWO) ? ST_EXTRA2 : ST_EXEC;
                ST_EXTRA2: state_q <= ST_EXEC;
                default: state_q <= ST_EXEC;
            endcase
        end
    end

    // operand fields, latched only when a real instruction is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            group_q <= ITD_GROUP_BYTE;
            op_q <= ITD_OP_OTHER;
            faddr_q <= '0;
            dest_file_q <= 1'b0;
            bitnum_q <= '0;
            literal_q <= '0;
            ptr_sel_q <= 1'b0;
            ptr_mode_q <= ITD_MODE_PRE_INC;
        end else if (cycle_end && state_q == ST_EXEC) begin
            group_q <= grp_d;
            op_q <= op_d;
            faddr_q <= word_d[FADDR_LSB +: FADDR_W];
            dest_file_q <= word_d[DEST_BIT];
            bitnum_q <= word_d[BITNUM_LSB +: BIT_W];
            literal_q <= word_d[LIT11_W-1:0];
            ptr_sel_q <= word_d[PTR_BIT];
            ptr_mode_q <= word_d[MODE_LSB +: 2];
        end
    end

    // access strobes: a squashed cycle touches nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            file_rd_q <= 1'b0;
            file_wr_q <= 1'b0;
            acc_wr_q <= 1'b0;
        end else begin
            file_rd_q <= cycle_end && state_q == ST_EXEC && file_d;
            file_wr_q <= cycle_end && state_q == ST_EXEC && file_d && (grp_d == ITD_GROUP_BIT || word_d[DEST_BIT]);
            acc_wr_q <= cycle_end && state_q == ST_EXEC && file_d && grp_d == ITD_GROUP_BYTE
                        && !word_d[DEST_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= PHASE_FIRST;
            exec_q <= 1'b0;
            squash_q <= 1'b0;
            insn_done_q <= 1'b0;
        end else begin
            phase_q <= phase;
            exec_q <= cycle_end && state_q == ST_EXEC;
            squash_q <= cycle_end && state_q != ST_EXEC;
            insn_done_q <= cycle_end && ((state_q == ST_EXEC && extra_d == 2'h0)
                           || (state_q == ST_EXTRA1 && extra_q != CYC_TWO) || state_q == ST_EXTRA2);
        end
    end

    // previous word, kept only so the capture checks can see what was decoded
    logic [WORD_W-1:0] insn_prev_q;
    always_ff @(posedge clk) begin
        insn_prev_q <= insn;
    end

    squash_no_write_a: assert property (@(posedge clk) disable iff (rst)
        squash_q |-> !file_wr_q && !acc_wr_q && !file_rd_q)
        else $error("squashed cycle touched state");
    squash_only_a: assert property (@(posedge clk) disable iff (rst)
        squash_q |-> !exec_q)
        else $error("squashed cycle also decoded a word");
    call_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_CALL |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("call did not take two cycles");
    callacc_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_CALL_VIA_ACC |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("call via accumulator did not take two cycles");
    ret_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_RETURN |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("return not two cycles");
    retlit_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_RETURN_WITH_LITERAL |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("return with literal not two cycles");
    retint_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_RETURN_FROM_INTERRUPT |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("return from interrupt not two cycles");
    branch_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_RELATIVE_BRANCH |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("branch not two cycles");
    jump_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_JUMP |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("jump not two cycles");
    bracc_two_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_BRANCH_BY_ACC |-> !insn_done_q ##4 (squash_q && insn_done_q))
        else $error("branch by accumulator not two cycles");
    skip_taken_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q inside {ITD_OP_SKIP_IF_BIT_SET, ITD_OP_SKIP_IF_BIT_CLEAR, ITD_OP_DECREMENT_SKIP_ZERO,
            ITD_OP_INCREMENT_SKIP_ZERO} && $past(skip_cond) |-> !insn_done_q ##4 squash_q)
        else $error("taken skip did not add a cycle");
    skip_not_taken_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q inside {ITD_OP_SKIP_IF_BIT_SET, ITD_OP_SKIP_IF_BIT_CLEAR, ITD_OP_DECREMENT_SKIP_ZERO,
            ITD_OP_INCREMENT_SKIP_ZERO} && !$past(skip_cond) && !$past(indirect_d) |-> insn_done_q)
        else $error("skip that does not skip took extra time");
    indirect_extra_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && $past(indirect_d) |-> !insn_done_q ##4 squash_q)
        else $error("indirect access at program memory did not add a cycle");
    plain_one_cyc_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && op_q == ITD_OP_OTHER && !$past(indirect_d) |-> insn_done_q)
        else $error("plain instruction took extra time");
    done_slot_a: assert property (@(posedge clk) disable iff (rst)
        insn_done_q |-> exec_q || squash_q)
        else $error("instruction ended outside an instruction cycle");
    wr_after_rd_a: assert property (@(posedge clk) disable iff (rst)
        file_wr_q |-> file_rd_q)
        else $error("file write without read");
    rd_on_exec_a: assert property (@(posedge clk) disable iff (rst)
        file_rd_q |-> exec_q)
        else $error("file read outside a decode cycle");
    bit_rmw_a: assert property (@(posedge clk) disable iff (rst)
        exec_q && group_q == ITD_GROUP_BIT |-> file_rd_q && file_wr_q && !acc_wr_q)
        else $error("bit operation did not write its file register");
    acc_dest_a: assert property (@(posedge clk) disable iff (rst)
        acc_wr_q |-> !dest_file_q && !file_wr_q)
        else $error("accumulator write with file destination");
    exec_spacing_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |=> !exec_q [*3])
        else $error("decode faster than one instruction cycle");
    group_legal_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |-> group_q inside {ITD_GROUP_BYTE, ITD_GROUP_BIT, ITD_GROUP_LITCTL})
        else $error("decoded group is not one of the three");
    faddr_capture_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |-> faddr_q == insn_prev_q[FADDR_LSB +: FADDR_W])
        else $error("file address not taken from the word");
    dest_capture_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |-> dest_file_q == insn_prev_q[DEST_BIT])
        else $error("destination bit not taken from the word");
    bitnum_capture_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |-> bitnum_q == insn_prev_q[BITNUM_LSB +: BIT_W])
        else $error("bit number not taken from the word");
    literal_capture_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |-> literal_q == insn_prev_q[LIT11_W-1:0])
        else $error("literal not taken from the word");
    ptr_sel_capture_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |-> ptr_sel_q == insn_prev_q[PTR_BIT])
        else $error("pointer number not taken from the word");
    ptr_mode_capture_a: assert property (@(posedge clk) disable iff (rst)
        exec_q |-> ptr_mode_q == insn_prev_q[MODE_LSB +: 2])
        else $error("pointer mode not taken from the word");

    cov_call_c: cover property (@(posedge clk) exec_q && op_q == ITD_OP_CALL);
    cov_skip_c: cover property (@(posedge clk) exec_q && op_q == ITD_OP_SKIP_IF_BIT_SET && squash_q == 1'b0);
    cov_three_c: cover property (@(posedge clk) state_q == ST_EXTRA2);
    cov_acc_c: cover property (@(posedge clk) acc_wr_q);
    cov_indirect_c: cover property (@(posedge clk) exec_q && op_q == ITD_OP_OTHER && !insn_done_q);
endmodule

// ===== itd_fetch_model.sv
// fetch path model: serves program words and their execution status
module itd_fetch_model
    import itd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // decoder feedback
    input wire logic insn_done_q,
    // fetched word and status
    output logic [INSN_W-1:0] insn,
    output logic skip_cond,
    output logic [1:0] ptr_in_prog
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [INSN_W-1:0] mem [256];
    logic sk [256];
    logic [1:0] pp [256];
    logic [7:0] pc = 8'h00;

    task automatic put(input int i, input logic [INSN_W-1:0] w, input logic s, input logic [1:0] p);
        mem[i] = w;
        sk[i] = s;
        pp[i] = p;
    endtask

    // advance only once the word is retired, so squashed cycles refetch nothing
    always @(negedge clk) begin
        if (rst) begin
            pc <= 8'h00;
        end else if (insn_done_q === 1'b1) begin
            pc <= pc + 8'h01;
        end
    end

    assign insn = mem[pc];
    assign skip_cond = sk[pc];
    assign ptr_in_prog = pp[pc];
endmodule

// ===== itd_phase_gen.sv
// phase counter: four oscillator cycles make one instruction cycle
module itd_phase_gen
    import itd_pkg::*;
#(
    parameter int unsigned PHASE_COUNT = PHASES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // phase outputs
    output logic [1:0] phase_q,
    output logic cycle_end_q
);
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= PHASE_FIRST;
        end else begin
            phase_q <= (phase_q == 2'(PHASE_COUNT - 1)) ? PHASE_FIRST : phase_q + 2'h1;
        end
    end

    // registered so it lines up with phase 3 of the counter
    always_ff @(posedge clk) begin
        if (rst) begin
            cycle_end_q <= 1'b0;
        end else begin
            cycle_end_q <= (phase_q == 2'(PHASE_COUNT - 2));
        end
    end

    cycle_len_a: assert property (@(posedge clk) disable iff (rst)
        cycle_end_q |=> !cycle_end_q [*3] ##1 cycle_end_q)
        else $error("instruction cycle is not four oscillator cycles");
endmodule

// ===== itd_pkg.sv
// package: opcode groups, field positions, op kinds and timing constants for the instruction decoder
package itd_pkg;
    localparam int unsigned INSN_W = 14;
    localparam int unsigned FADDR_W = 7;
    localparam int unsigned BIT_W = 3;
    localparam int unsigned LIT8_W = 8;
    localparam int unsigned LIT11_W = 11;
    localparam int unsigned PHASES = 4;
    localparam int unsigned OSC_NS = 25;
    localparam int unsigned FADDR_LSB = 0;
    localparam int unsigned DEST_BIT = 7;
    localparam int unsigned BITNUM_LSB = 7;
    localparam int unsigned PTR_BIT = 2;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned GROUP_LSB = 12;
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;
    localparam logic [6:0] INDIRECT0_ADDR = 7'h00;
    localparam logic [6:0] INDIRECT1_ADDR = 7'h01;
    localparam logic [6:0] FADDR_MAX = 7'h7f;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_FIRST = 2'h0;

    typedef enum logic [1:0] {
        ITD_GROUP_BYTE = 2'h0,
        ITD_GROUP_BIT = 2'h1,
        ITD_GROUP_LITCTL = 2'h2
    } itd_group_e;

    typedef enum logic [3:0] {
        ITD_OP_OTHER = 4'h0,
        ITD_OP_CALL = 4'h1,
        ITD_OP_JUMP = 4'h2,
        ITD_OP_CALL_VIA_ACC = 4'h3,
        ITD_OP_RETURN = 4'h4,
        ITD_OP_RETURN_WITH_LITERAL = 4'h5,
        ITD_OP_RETURN_FROM_INTERRUPT = 4'h6,
        ITD_OP_RELATIVE_BRANCH = 4'h7,
        ITD_OP_BRANCH_BY_ACC = 4'h8,
        ITD_OP_SKIP_IF_BIT_SET = 4'h9,
        ITD_OP_SKIP_IF_BIT_CLEAR = 4'ha,
        ITD_OP_DECREMENT_SKIP_ZERO = 4'hb,
        ITD_OP_INCREMENT_SKIP_ZERO = 4'hc,
        ITD_OP_POINTER_OP = 4'hd
    } itd_op_e;

    typedef enum logic [1:0] {
        ITD_MODE_PRE_INC = 2'h0,
        ITD_MODE_PRE_DEC = 2'h1,
        ITD_MODE_POST_INC = 2'h2,
        ITD_MODE_POST_DEC = 2'h3
    } itd_mode_e;

    // fixed opcode patterns; the 6-bit ones match bits 13:8, the others are sized to the bits they match
    localparam logic [5:0] OPC_DECSKIP_HI = 6'h0b;
    localparam logic [5:0] OPC_INCSKIP_HI = 6'h0f;
    localparam logic [1:0] OPC_BITSET_HI = 2'h3;
    localparam logic [1:0] OPC_BITCLR_HI = 2'h2;
    localparam logic [13:0] OPC_RETURN = 14'h0008;
    localparam logic [13:0] OPC_RETFROMINT = 14'h0009;
    localparam logic [13:0] OPC_CALLACC = 14'h000a;
    localparam logic [13:0] OPC_BRACC = 14'h000b;
    localparam logic [2:0] OPC_CALL_TOP = 3'h4;
    localparam logic [2:0] OPC_GOTO_TOP = 3'h5;
    localparam logic [5:0] OPC_RETLIT_HI = 6'h34;
    localparam logic [4:0] OPC_RELBR_TOP = 5'h19;
    localparam logic [10:0] OPC_PTROP_TOP = 11'h002;
endpackage
